/* File: bfm_pkg.sv */
// Constants and types shared by the bridge fault manager.
package bfm_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ       = 10;
  localparam int T_ISD_US      = 1;
  localparam int ISD_CYC       = T_ISD_US * CLK_MHZ;
  localparam int T_DOC_US      = 5;
  localparam int DOC_CYC       = T_DOC_US * CLK_MHZ;
  localparam int T_REC_US      = 7;
  localparam int REC_CYC       = T_REC_US * CLK_MHZ;
  localparam int T_RST_NS      = 300;
  localparam int RST_CYC       = (T_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int T_LOAD_US     = 5;
  localparam int LOAD_CYC      = T_LOAD_US * CLK_MHZ;
  localparam int T_BLK_SLOW_NS = 1500;
  localparam int BLK_SLOW_CYC  = (T_BLK_SLOW_NS * CLK_MHZ + 999) / 1000;
  localparam int T_BLK_FAST_NS = 1000;
  localparam int BLK_FAST_CYC  = (T_BLK_FAST_NS * CLK_MHZ + 999) / 1000;
  localparam int T_DT_SLOW_NS  = 4500;
  localparam int DT_SLOW_CYC   = (T_DT_SLOW_NS * CLK_MHZ + 999) / 1000;
  localparam int T_DT_FAST_NS  = 2500;
  localparam int DT_FAST_CYC   = (T_DT_FAST_NS * CLK_MHZ + 999) / 1000;
  localparam int T_STBY_US     = 50;
  localparam int STBY_CYC      = T_STBY_US * CLK_MHZ;
  localparam int OTF_CYC       = 10;
  localparam int CNT_W         = 10;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam int             ADDR_W      = 4;
  localparam logic [3:0]     ADDR_CTRL   = 4'h0;
  localparam logic [3:0]     ADDR_STAT   = 4'h4;
  localparam logic [7:0]     CTRL_RST    = 8'h00;
  localparam logic [11:0]    SENSE_RATIO = 12'h08ca;

  typedef struct packed {
    logic en;
    logic fast;
    logic sense_en;
    logic sel_a;
    logic pwm;
    logic in_b;
    logic in_a;
    logic rd_status;
  } bfm_ctrl_type;

  typedef struct packed {
    logic en;
    logic thermal_off_flag_b;
    logic thermal_off_flag_a;
    logic supply_low_flag;
    logic open_load_flag;
    logic oc_b;
    logic oc_a;
    logic rd_status;
  } bfm_stat_type;

  typedef struct packed {
    logic hs_on;
    logic ls_on;
  } bfm_sw_type;

  typedef struct packed {
    logic hs;
    logic ls;
  } bfm_oc_type;

  typedef enum logic [1:0] {
    SNS_OFF   = 2'h0,
    SNS_PROP  = 2'h1,
    SNS_FAULT = 2'h3
  } bfm_sense_type;

endpackage : bfm_pkg

/* File: bfm_filt.sv */
// Qualification counter: done once cond has held for N cycles.
`timescale 1ns/1ps
`default_nettype none
module bfm_filt #(
  parameter int N = 1
) (
  input  wire logic core_clk,
  input  wire logic rstn,
  input  wire logic cond,
  output logic      done
);

  localparam logic [bfm_pkg::CNT_W-1:0] LIM = bfm_pkg::CNT_W'(N);

  logic [bfm_pkg::CNT_W-1:0] cnt_r;

  // ----------------------------------------
  // Counter restarts whenever cond drops
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      cnt_r <= '0;
    else if (!cond)
      cnt_r <= '0;
    else if (cnt_r != LIM)
      cnt_r <= cnt_r + 1'b1;
  end

  assign done = cond && (cnt_r == LIM);

endmodule : bfm_filt
`default_nettype wire

/* File: bfm_hb.sv */
// One half-bridge: dead time, overcurrent latch and release.
`timescale 1ns/1ps
`default_nettype none
module bfm_hb (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic        cmd_hs,
  input  wire logic        cmd_ls,
  input  wire logic        in_x,
  input  wire logic        pwm,
  input  wire logic        fast,
  input  wire logic        force_off,
  input  var  bfm_pkg::bfm_oc_type oc,
  output bfm_pkg::bfm_sw_type sw,
  output logic             oc_flag,
  output logic             limiting
);

  localparam logic [bfm_pkg::CNT_W-1:0] DT_F = bfm_pkg::CNT_W'(bfm_pkg::DT_FAST_CYC);
  localparam logic [bfm_pkg::CNT_W-1:0] DT_S = bfm_pkg::CNT_W'(bfm_pkg::DT_SLOW_CYC);

  logic                      hs_on_r;
  logic                      ls_on_r;
  logic                      hs_nxt;
  logic                      ls_nxt;
  logic                      hs_lat_r;
  logic                      ls_lat_r;
  logic                      hs_arm_r;
  logic                      ls_arm_r;
  logic                      hs_trip;
  logic                      ls_trip;
  logic                      hs_low;
  logic                      ls_low;
  logic                      hs_rec;
  logic                      ls_rec;
  logic [bfm_pkg::CNT_W-1:0] dt_r;

  // ----------------------------------------
  // Overcurrent filters and release timing
  // ----------------------------------------
  bfm_filt #(.N(bfm_pkg::DOC_CYC)) u_doc_hs (.core_clk(core_clk), .rstn(rstn),
    .cond(oc.hs && hs_on_r), .done(hs_trip));
  bfm_filt #(.N(bfm_pkg::DOC_CYC)) u_doc_ls (.core_clk(core_clk), .rstn(rstn),
    .cond(oc.ls && ls_on_r), .done(ls_trip));
  bfm_filt #(.N(bfm_pkg::RST_CYC)) u_low_hs (.core_clk(core_clk), .rstn(rstn),
    .cond(!in_x), .done(hs_low));
  bfm_filt #(.N(bfm_pkg::RST_CYC)) u_low_ls (.core_clk(core_clk), .rstn(rstn),
    .cond(!pwm), .done(ls_low));
  bfm_filt #(.N(bfm_pkg::REC_CYC)) u_rec_hs (.core_clk(core_clk), .rstn(rstn),
    .cond(hs_lat_r && hs_arm_r && cmd_hs), .done(hs_rec));
  bfm_filt #(.N(bfm_pkg::REC_CYC)) u_rec_ls (.core_clk(core_clk), .rstn(rstn),
    .cond(ls_lat_r && ls_arm_r && cmd_ls), .done(ls_rec));

  assign limiting = oc.hs || oc.ls;

  // ----------------------------------------
  // Latches: a new trip wins over release
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      hs_lat_r <= 1'b0;
      ls_lat_r <= 1'b0;
      hs_arm_r <= 1'b0;
      ls_arm_r <= 1'b0;
    end
    else
    begin
      hs_lat_r <= hs_trip || (hs_lat_r && !hs_rec);
      ls_lat_r <= ls_trip || (ls_lat_r && !ls_rec);
      hs_arm_r <= hs_lat_r && !hs_rec && (hs_arm_r || hs_low);
      ls_arm_r <= ls_lat_r && !ls_rec && (ls_arm_r || ls_low);
    end
  end

  assign oc_flag = hs_lat_r || ls_lat_r;

  // ----------------------------------------
  // Gate drive with dead time
  // ----------------------------------------
  always_comb
  begin
    hs_nxt = hs_on_r;
    ls_nxt = ls_on_r;
    if (!cmd_hs || hs_lat_r || force_off)
      hs_nxt = 1'b0;
    else if (dt_r == '0 && !ls_on_r)
      hs_nxt = 1'b1;
    if (!cmd_ls || ls_lat_r || force_off || cmd_hs)
      ls_nxt = 1'b0;
    else if (dt_r == '0 && !hs_on_r)
      ls_nxt = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      hs_on_r <= 1'b0;
      ls_on_r <= 1'b0;
      dt_r    <= '0;
    end
    else
    begin
      hs_on_r <= hs_nxt;
      ls_on_r <= ls_nxt;
      if ((hs_on_r && !hs_nxt) || (ls_on_r && !ls_nxt))
        dt_r <= fast ? DT_F : DT_S;
      else if (dt_r != '0)
        dt_r <= dt_r - 1'b1;
    end
  end

  assign sw.hs_on = hs_on_r;
  assign sw.ls_on = ls_on_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_no_cross: assert property (@(posedge core_clk) disable iff (!rstn)
    !(hs_on_r && ls_on_r)) else $error("both switches of a half-bridge on");
  a_dead_gap: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(ls_on_r) |-> $past(dt_r) == '0 && !$past(hs_on_r))
    else $error("low side on without dead time");
  a_latch_off: assert property (@(posedge core_clk) disable iff (!rstn)
    hs_lat_r |=> !hs_on_r) else $error("latched high side still on");
  a_release_cmd: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(hs_lat_r) |-> $past(cmd_hs) && $past(hs_arm_r))
    else $error("latch released without command");

endmodule : bfm_hb
`default_nettype wire

/* File: bfm_top.sv */
// Fault manager of a full-bridge driver with Avalon-MM registers.
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module bfm_top (
  input  wire logic        core_clk,
  input  wire logic        rstn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        supply_low_det,
  input  wire logic        supply_ok_det,
  input  wire logic [1:0]  over_temp_det,
  input  wire logic [1:0]  temp_ok_det,
  input  wire logic        load_fault_det,
  input  var  bfm_pkg::bfm_oc_type oc_a_det,
  input  var  bfm_pkg::bfm_oc_type oc_b_det,
  output bfm_pkg::bfm_sw_type output_a,
  output bfm_pkg::bfm_sw_type output_b,
  output logic [1:0]       current_limit,
  output logic             charge_pump_on,
  output bfm_pkg::bfm_sense_type sense_current_output,
  output logic             sense_sel_a,
  output logic [11:0]      sense_ratio,
  output logic             summary_fault_flag,
  output logic             standby
);

  localparam int A_STBY = bfm_pkg::STBY_CYC;
  localparam int A_LOAD = bfm_pkg::LOAD_CYC;
  localparam logic [bfm_pkg::CNT_W-1:0] BLK_F = bfm_pkg::CNT_W'(bfm_pkg::BLK_FAST_CYC);
  localparam logic [bfm_pkg::CNT_W-1:0] BLK_S = bfm_pkg::CNT_W'(bfm_pkg::BLK_SLOW_CYC);

  bfm_pkg::bfm_ctrl_type     ctrl_r;
  bfm_pkg::bfm_stat_type     stat;
  bfm_pkg::bfm_sense_type    sns_r;
  bfm_pkg::bfm_sense_type    sns_nxt;
  bfm_pkg::bfm_sw_type       sw_a;
  bfm_pkg::bfm_sw_type       sw_b;
  bfm_pkg::bfm_sw_type       sw_a_d_r;
  bfm_pkg::bfm_sw_type       sw_b_d_r;
  logic                      ack_r;
  logic [31:0]               rdata_r;
  logic                      supply_low_flag_r;
  logic [1:0]                thermal_off_flag_r;
  logic [1:0]                hot_done;
  logic                      open_load_flag_r;
  logic                      load_cond;
  logic                      load_done;
  logic                      sns_ready;
  logic [1:0]                oc_flag;
  logic [bfm_pkg::CNT_W-1:0] blk_r;
  logic                      fault_sum_r;
  logic                      stby_r;
  logic                      cmd_hs_a;
  logic                      cmd_ls_a;
  logic                      cmd_hs_b;
  logic                      cmd_ls_b;
  logic                      any_fault;

  // ----------------------------------------
  // Avalon-MM slave, one wait cycle per access
  // ----------------------------------------
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
  assign avs_readdata    = rdata_r;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      ack_r   <= 1'b0;
      rdata_r <= '0;
      ctrl_r  <= bfm_pkg::CTRL_RST;
    end
    else
    begin
      ack_r <= (avs_read || avs_write) && !ack_r;
      if (avs_read && !ack_r)
      begin
        unique case (avs_address)
          bfm_pkg::ADDR_CTRL: rdata_r <= {24'h00_0000, ctrl_r};
          bfm_pkg::ADDR_STAT: rdata_r <= {23'h00_0000, fault_sum_r, stat};
          default:            rdata_r <= '0;
        endcase
      end
      if (avs_write && ack_r && avs_address == bfm_pkg::ADDR_CTRL)
        ctrl_r <= avs_writedata[7:0];
    end
  end

  assign stat = '{en: ctrl_r.en, thermal_off_flag_b: thermal_off_flag_r[1],
                  thermal_off_flag_a: thermal_off_flag_r[0],
                  supply_low_flag: supply_low_flag_r, open_load_flag: open_load_flag_r,
                  oc_b: oc_flag[1], oc_a: oc_flag[0], rd_status: ctrl_r.rd_status};

  // ----------------------------------------
  // Supply and thermal flags, set wins
  // ----------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      supply_low_flag_r  <= 1'b0;
      thermal_off_flag_r <= '0;
    end
    else
    begin
      supply_low_flag_r <= supply_low_det || (supply_low_flag_r && !supply_ok_det);
      for (int i = 0; i < 2; i++)
        thermal_off_flag_r[i] <= hot_done[i] ||
                                 (thermal_off_flag_r[i] && !temp_ok_det[i]);
    end
  end

  for (genvar g = 0; g < 2; g++)
  begin : g_hot
    bfm_filt #(.N(bfm_pkg::OTF_CYC)) u_otf (.core_clk(core_clk), .rstn(rstn),
      .cond(over_temp_det[g]), .done(hot_done[g]));
  end

  bfm_filt #(.N(bfm_pkg::ISD_CYC)) u_isd (.core_clk(core_clk), .rstn(rstn),
    .cond(!supply_low_flag_r), .done(sns_ready));

  // ----------------------------------------
  // Open load and short to ground
  // ----------------------------------------
  always_comb
  begin
    load_cond = 1'b0;
    if (load_fault_det && !ctrl_r.pwm)
    begin
      unique case ({ctrl_r.in_a, ctrl_r.in_b, ctrl_r.sel_a})
        3'h4, 3'h3, 3'h1: load_cond = 1'b1;
        default:          load_cond = 1'b0;
      endcase
    end
  end

  bfm_filt #(.N(bfm_pkg::LOAD_CYC)) u_load (.core_clk(core_clk), .rstn(rstn),
    .cond(load_cond), .done(load_done));

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      open_load_flag_r <= 1'b0;
    else
      open_load_flag_r <= load_done;
  end

  // ----------------------------------------
  // Half-bridges
  // ----------------------------------------
  assign cmd_hs_a = ctrl_r.en && ctrl_r.pwm && ctrl_r.in_a;
  assign cmd_ls_a = ctrl_r.en && ctrl_r.pwm && !ctrl_r.in_a;
  assign cmd_hs_b = ctrl_r.en && ctrl_r.pwm && ctrl_r.in_b;
  assign cmd_ls_b = ctrl_r.en && ctrl_r.pwm && !ctrl_r.in_b;

  bfm_hb u_hb_a (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .cmd_hs    (cmd_hs_a),
    .cmd_ls    (cmd_ls_a),
    .in_x      (ctrl_r.in_a),
    .pwm       (ctrl_r.pwm),
    .fast      (ctrl_r.fast),
    .force_off (supply_low_flag_r || thermal_off_flag_r[0]),
    .oc        (oc_a_det),
    .sw        (sw_a),
    .oc_flag   (oc_flag[0]),
    .limiting  (current_limit[0])
  );

  bfm_hb u_hb_b (
    .core_clk  (core_clk),
    .rstn      (rstn),
    .cmd_hs    (cmd_hs_b),
    .cmd_ls    (cmd_ls_b),
    .in_x      (ctrl_r.in_b),
    .pwm       (ctrl_r.pwm),
    .fast      (ctrl_r.fast),
    .force_off (supply_low_flag_r || thermal_off_flag_r[1]),
    .oc        (oc_b_det),
    .sw        (sw_b),
    .oc_flag   (oc_flag[1]),
    .limiting  (current_limit[1])
  );

  assign output_a = sw_a;
  assign output_b = sw_b;

  // ----------------------------------------
  // Sense output state and blanking
  // ----------------------------------------
  assign any_fault = |thermal_off_flag_r || |oc_flag || open_load_flag_r;

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      sw_a_d_r <= '0;
      sw_b_d_r <= '0;
      blk_r    <= '0;
    end
    else
    begin
      sw_a_d_r <= sw_a;
      sw_b_d_r <= sw_b;
      if (sw_a != sw_a_d_r || sw_b != sw_b_d_r)
        blk_r <= ctrl_r.fast ? BLK_F : BLK_S;
      else if (blk_r != '0)
        blk_r <= blk_r - 1'b1;
    end
  end

  always_comb
  begin
    if (!ctrl_r.en || supply_low_flag_r || !sns_ready)
      sns_nxt = bfm_pkg::SNS_OFF;
    else if (any_fault)
      sns_nxt = bfm_pkg::SNS_FAULT;
    else if (ctrl_r.sense_en && blk_r == '0)
      sns_nxt = bfm_pkg::SNS_PROP;
    else
      sns_nxt = bfm_pkg::SNS_OFF;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      sns_r       <= bfm_pkg::SNS_OFF;
      sense_sel_a <= 1'b0;
      fault_sum_r <= 1'b0;
      stby_r      <= 1'b1;
    end
    else
    begin
      sns_r       <= sns_nxt;
      sense_sel_a <= ctrl_r.sel_a;
      fault_sum_r <= |thermal_off_flag_r || supply_low_flag_r ||
                     open_load_flag_r || |oc_flag;
      stby_r      <= !ctrl_r.en;
    end
  end

  assign sense_current_output = sns_r;
  assign sense_ratio          = bfm_pkg::SENSE_RATIO;
  assign summary_fault_flag   = fault_sum_r;
  assign standby              = stby_r;
  assign charge_pump_on       = !stby_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_supply_off: assert property (@(posedge core_clk) disable iff (!rstn)
    supply_low_flag_r |=> !output_a.hs_on && !output_a.ls_on &&
                          !output_b.hs_on && !output_b.ls_on)
    else $error("switch on during undervoltage");
  a_supply_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
    supply_low_flag_r |=> sense_current_output == bfm_pkg::SNS_OFF)
    else $error("sense active during undervoltage");
  a_sense_recov: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(supply_low_flag_r) |-> (sense_current_output == bfm_pkg::SNS_OFF)[*8])
    else $error("sense back before recovery time");
  a_summary_or: assert property (@(posedge core_clk) disable iff (!rstn)
    summary_fault_flag == $past(any_fault || supply_low_flag_r))
    else $error("summary flag does not match fault flags");
  a_load_filter: assert property (@(posedge core_clk) disable iff (!rstn)
    $rose(open_load_flag_r) |-> $past(load_cond, A_LOAD))
    else $error("open load flagged before filter time");
  a_blank_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
    blk_r != '0 |=> sense_current_output != bfm_pkg::SNS_PROP)
    else $error("proportional sense during blanking");
  a_hot_off_b: assert property (@(posedge core_clk) disable iff (!rstn)
    thermal_off_flag_r[1] |=> !output_b.hs_on && !output_b.ls_on)
    else $error("overheated half-bridge still on");
  a_stby_time: assert property (@(posedge core_clk) disable iff (!rstn)
    $fell(ctrl_r.en) |-> ##[1:A_STBY] standby)
    else $error("standby not reached in time");

endmodule : bfm_top
`default_nettype wire

/* File: bfm_host.sv */
// Host model: Avalon master that writes and reads the control bytes.
`timescale 1ns/1ps
`default_nettype none
module bfm_host (
  input  wire logic        core_clk,
  input  wire logic        avs_waitrequest,
  output logic [3:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata
);
  logic [31:0] exp_q[$];

  initial
  begin
    avs_address   = 4'h0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
  end

  // Holds the request until waitrequest is seen low at an edge.
  task automatic xfer(input logic [3:0] a, input logic w, input logic [31:0] d);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= ~w;
    avs_writedata <= d;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge core_clk);
  endtask : xfer

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    xfer(a, 1'b1, {24'h00_0000, d});
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(a, 1'b0, 32'h0000_0000);
  endtask : rd

  // Clears a latch: input low for the reset time, then the on command.
  task automatic unlatch(input logic [7:0] off, input logic [7:0] on);
    wr(bfm_pkg::ADDR_CTRL, off);
    repeat (bfm_pkg::RST_CYC) @(posedge core_clk);
    wr(bfm_pkg::ADDR_CTRL, on);
  endtask : unlatch
endmodule : bfm_host
`default_nettype wire

/* File: bfm_tb.sv */
// Self-checking testbench of the bridge fault manager.
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam logic [3:0] CA  = bfm_pkg::ADDR_CTRL;
  localparam logic [3:0] SA  = bfm_pkg::ADDR_STAT;
  localparam logic [7:0] RUN = 8'hba;
  localparam logic [7:0] OLP [3] = '{8'ha2, 8'hb4, 8'hb0};
  logic                   core_clk = 1'b0;
  logic                   rstn = 1'b0;
  logic [3:0]             avs_address;
  logic                   avs_read;
  logic                   avs_write;
  logic [31:0]            avs_writedata;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  logic                   supply_low_det = 1'b0;
  logic                   supply_ok_det = 1'b1;
  logic [1:0]             over_temp_det = 2'h0;
  logic [1:0]             temp_ok_det = 2'h3;
  logic                   load_fault_det = 1'b0;
  bfm_pkg::bfm_oc_type    oc_a_det = 2'h0;
  bfm_pkg::bfm_oc_type    oc_b_det = 2'h0;
  bfm_pkg::bfm_sw_type    output_a;
  bfm_pkg::bfm_sw_type    output_b;
  logic [1:0]             current_limit;
  logic                   charge_pump_on;
  bfm_pkg::bfm_sense_type sense_current_output;
  logic                   sense_sel_a;
  logic [11:0]            sense_ratio;
  logic                   summary_fault_flag;
  logic                   standby;
  logic [1:0]             sw_now;
  int                     err_count = 0;
  int                     n_tests = 0;

  assign sw_now = {output_b.ls_on, output_a.hs_on};

  always #50 core_clk = ~core_clk;

  bfm_top dut (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .supply_low_det(supply_low_det), .supply_ok_det(supply_ok_det),
    .over_temp_det(over_temp_det), .temp_ok_det(temp_ok_det),
    .load_fault_det(load_fault_det), .oc_a_det(oc_a_det), .oc_b_det(oc_b_det),
    .output_a(output_a), .output_b(output_b), .current_limit(current_limit),
    .charge_pump_on(charge_pump_on), .sense_current_output(sense_current_output),
    .sense_sel_a(sense_sel_a), .sense_ratio(sense_ratio),
    .summary_fault_flag(summary_fault_flag), .standby(standby));

  bfm_host host (.core_clk(core_clk), .avs_waitrequest(avs_waitrequest),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata));

  // ----------------------------------------
  // Compare and helper tasks
  // ----------------------------------------
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_pin(input string nm, input logic [11:0] e, input logic [11:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_pin

  task automatic chk_sense(input bfm_pkg::bfm_sense_type e);
    chk_pin("sense", {10'h000, e}, {10'h000, sense_current_output});
  endtask : chk_sense

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask : cyc

  task automatic set_oc(input int i, input logic v);
    if (i == 0)
      oc_a_det.hs <= v;
    else
      oc_b_det.ls <= v;
  endtask : set_oc

  function automatic logic [31:0] stw(input logic [7:0] f);
    return {23'h00_0000, |f[6:1], f};
  endfunction : stw

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Monitors
  // ----------------------------------------
  always @(posedge core_clk)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
      chk_word("readdata", host.exp_q.pop_front(), avs_readdata);
    if (rstn === 1'b1)
    begin
      chk_pin("overlap_a", 12'h000, {11'h000, &output_a});
      chk_pin("overlap_b", 12'h000, {11'h000, &output_b});
    end
  end

  initial
  begin
    repeat (8000) @(posedge core_clk);
    err_count++;
    print_verdict();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    logic [31:0] r;
    int          n;
    r = $urandom(69702);
    cyc(12);
    rstn <= 1'b1;
    cyc(1);
    chk_pin("standby", 12'h001, {11'h000, standby});
    r = $urandom;
    host.xfer(4'h8, 1'b1, r);
    host.xfer(SA, 1'b1, r);
    host.rd(4'h8, 32'h0000_0000);
    host.rd(CA, 32'h0000_0000);
    r = $urandom & 32'h0000_007e;
    host.wr(CA, r[7:0]);
    host.rd(CA, r);
    host.wr(CA, RUN);
    cyc(80);
    chk_pin("out_a", 12'h002, {10'h000, output_a});
    chk_pin("out_b", 12'h001, {10'h000, output_b});
    chk_sense(bfm_pkg::SNS_PROP);
    chk_pin("ratio", 12'h08ca, sense_ratio);
    chk_pin("sel", 12'h001, {11'h000, sense_sel_a});
    host.rd(SA, stw(8'h80));
    host.wr(CA, RUN & 8'hef);
    cyc(1);
    chk_pin("sel", 12'h000, {11'h000, sense_sel_a});
    for (int f = 0; f < 2; f++)
    begin
      host.wr(CA, RUN | (f ? 8'h40 : 8'h00));
      cyc(80);
      host.wr(CA, (RUN & 8'hfd) | (f ? 8'h40 : 8'h00));
      cyc(20);
      chk_pin("dead_a", 12'h000, {10'h000, output_a});
      cyc(f ? 10 : 30);
      chk_sense(bfm_pkg::SNS_OFF);
      cyc(f ? 40 : 20);
      chk_pin("ls_a", 12'h001, {10'h000, output_a});
      chk_sense(bfm_pkg::SNS_PROP);
    end
    host.wr(CA, RUN);
    cyc(80);
    for (int i = 0; i < 2; i++)
    begin
      set_oc(i, 1'b1);
      cyc(30);
      set_oc(i, 1'b0);
      cyc(1);
      set_oc(i, 1'b1);
      cyc(2);
      chk_pin("limit", 12'h001 << i, {10'h000, current_limit});
      cyc(43);
      chk_pin("sw_kept", 12'h001, {11'h000, sw_now[i]});
      cyc(15);
      chk_pin("sw_latched", 12'h000, {11'h000, sw_now[i]});
      chk_sense(bfm_pkg::SNS_FAULT);
      chk_pin("summary", 12'h001, {11'h000, summary_fault_flag});
      set_oc(i, 1'b0);
      host.rd(SA, stw(i ? 8'h84 : 8'h82));
      host.unlatch(i ? 8'hb2 : 8'hb8, RUN);
      n = 0;
      while (sw_now[i] !== 1'b1 && n < 300)
      begin
        cyc(1);
        n++;
      end
      chk_pin("recovery", 12'h001, {11'h000, (n >= 69 && n <= 249)});
      host.rd(SA, stw(8'h80));
    end
    supply_low_det <= 1'b1;
    supply_ok_det  <= 1'b0;
    cyc(3);
    chk_pin("uv_off", 12'h000, {8'h00, output_a, output_b});
    chk_pin("pump", 12'h001, {11'h000, charge_pump_on});
    chk_sense(bfm_pkg::SNS_OFF);
    host.rd(SA, stw(8'h90));
    supply_low_det <= 1'b0;
    supply_ok_det  <= 1'b1;
    cyc(3);
    chk_sense(bfm_pkg::SNS_OFF);
    cyc(100);
    chk_pin("uv_back", 12'h002, {10'h000, output_a});
    chk_sense(bfm_pkg::SNS_PROP);
    host.rd(SA, stw(8'h80));
    over_temp_det <= 2'h2;
    temp_ok_det   <= 2'h1;
    cyc(6);
    chk_pin("ot_filter", 12'h001, {10'h000, output_b});
    cyc(8);
    chk_pin("ot_b", 12'h000, {10'h000, output_b});
    chk_pin("ot_a", 12'h002, {10'h000, output_a});
    chk_sense(bfm_pkg::SNS_FAULT);
    host.rd(SA, stw(8'hc0));
    over_temp_det <= 2'h0;
    temp_ok_det   <= 2'h3;
    cyc(60);
    chk_pin("ot_back", 12'h001, {10'h000, output_b});
    host.rd(SA, stw(8'h80));
    load_fault_det <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      host.wr(CA, RUN);
      cyc(5);
      host.wr(CA, OLP[k]);
      cyc(40);
      host.rd(SA, stw(8'h80));
      cyc(15);
      chk_sense(bfm_pkg::SNS_FAULT);
      host.rd(SA, stw(8'h88));
    end
    load_fault_det <= 1'b0;
    host.wr(CA, 8'h00);
    cyc(3);
    chk_pin("stby", 12'h001, {11'h000, standby});
    chk_pin("stby_pump", 12'h000, {11'h000, charge_pump_on});
    print_verdict();
  end
endmodule : tb
`default_nettype wire
